// ==== testbench/psd_core_model.sv ====
`timescale 1ns/1ps
module psd_core_model
  import psd_pkg::*;
(
  input  wire logic        clk_in,
  output psd_ps_req_t      req_out,
  input  wire logic [31:0] rdata_in,
  input  wire logic        rvalid_in
);
  initial req_out = '0;
  // Idle lines carry inverted junk so a stale address never looks valid
  task automatic ps_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_in);
    req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_in);
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : ps_wr
  task automatic ps_rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_in);
    req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(negedge clk_in);
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'hffff_ffff};
    for (int n = 0; n < 4 && rvalid_in !== 1'b1; n++) @(negedge clk_in);
    d = (rvalid_in === 1'b1) ? rdata_in : 32'hxxxx_xxxx;
  endtask : ps_rd
endmodule : psd_core_model

// ==== testbench/psd_status_regs_chk.sv ====
`timescale 1ns/1ps
module psd_status_regs_chk
  import psd_pkg::*;
#(
  parameter logic [31:0] RAM_BYTES = 32'h0004_0000
) (
  input wire logic           clk_sys_in,
  input wire logic           arst_n_in,
  input wire psd_ps_req_t    ps_req_in,
  input wire logic [31:0]    ps_rdata_out,
  input wire logic           ps_rvalid_out,
  input wire logic           ps_werr_out,
  input wire logic           otp_load_in,
  input wire logic [31:0]    otp_sec_word_in,
  input wire logic           debug_mode_in,
  input wire psd_dbg_entry_t dbg_entry_in,
  input wire logic [3:0]     ring_osc_clk_in,
  input wire psd_sec_ctrl_t  sec_ctrl_out,
  input wire logic [7:0]     thread_sel_out,
  input wire logic [4:0]     reg_sel_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  logic dwr;
  logic sec_wr;
  assign dwr    = ps_req_in.wr && debug_mode_in && !dbg_entry_in.valid;
  assign sec_wr = ps_req_in.wr && ps_req_in.addr == OFF_SEC_CFG;
  read_answer_a: assert property (ps_req_in.rd |=> ps_rvalid_out) else $error("read not answered");
  read_only_a: assert property (ps_rvalid_out |-> $past(ps_req_in.rd)) else $error("stray read valid");
  werr_cause_a: assert property (ps_werr_out |-> $past(sec_wr)) else $error("stray write refusal");
  tap_block_a: assert property (otp_load_in && otp_sec_word_in[0] |=> sec_ctrl_out.tap_block) else $error("tap");
  gdbg_block_a: assert property (otp_load_in && otp_sec_word_in[14] |=> sec_ctrl_out.gdbg_block) else $error("gdbg");
  all_lock_a: assert property (sec_ctrl_out.otp_all_lock |-> &sec_ctrl_out.otp_sector_lock) else $error("lock");
  thread_wr_a: assert property (dwr && ps_req_in.addr == OFF_THREAD_SEL
    |=> thread_sel_out == $past(ps_req_in.wdata[7:0])) else $error("thread select not written");
  regsel_wr_a: assert property (dwr && ps_req_in.addr == OFF_REG_SEL
    |=> reg_sel_out == $past(ps_req_in.wdata[4:0])) else $error("register select not written");
  sel_hold_a: assert property (!(ps_req_in.wr && debug_mode_in)
    |=> $stable({thread_sel_out, reg_sel_out})) else $error("operand changed outside debug");
  ram_size_a: assert property (ps_req_in.rd && ps_req_in.addr == OFF_RAM_SIZE
    |=> ps_rdata_out == (RAM_BYTES & RAM_SIZE_MASK)) else $error("ram size wrong");
  ctrl_resv_a: assert property (ps_req_in.rd && ps_req_in.addr == OFF_RO_CTRL
    |=> (ps_rdata_out & ~RO_CTRL_MASK) == ZERO_WORD) else $error("reserved bits set");
endmodule : psd_status_regs_chk
bind psd_status_regs psd_status_regs_chk #(.RAM_BYTES(RAM_BYTES)) chk_u (.*);

// ==== testbench/psd_status_regs_tb.sv ====
`timescale 1ns/1ps
module psd_status_regs_tb;
  import psd_pkg::*;
  localparam logic [31:0] RAM_B = 32'h0002_0000;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, otp_load_in = 1'b0, debug_mode_in = 1'b0, ps_rvalid_out, ps_werr_out;
  logic [31:0] otp_sec_word_in = '0, ps_rdata_out, v;
  logic [31:0] cnt [4];
  logic [3:0] ring_osc_clk_in = '0;
  logic [7:0] thread_sel_out;
  logic [4:0] reg_sel_out;
  psd_ps_req_t ps_req_in;
  psd_dbg_entry_t dbg_entry_in = '0;
  psd_sec_ctrl_t sec_ctrl_out;
  int n_fail = 0, check_count = 0, cyc = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  always #3 ring_osc_clk_in[0] = ~ring_osc_clk_in[0];
  always #3.5 ring_osc_clk_in[1] = ~ring_osc_clk_in[1];
  always #4.5 ring_osc_clk_in[2] = ~ring_osc_clk_in[2];
  always #5.5 ring_osc_clk_in[3] = ~ring_osc_clk_in[3];
  psd_status_regs #(.RAM_BYTES(RAM_B)) dut_u (.clk_sys_in, .arst_n_in, .ps_req_in, .ps_rdata_out, .ps_rvalid_out,
    .ps_werr_out, .otp_load_in, .otp_sec_word_in, .debug_mode_in, .dbg_entry_in, .ring_osc_clk_in, .sec_ctrl_out,
    .thread_sel_out, .reg_sel_out);
  psd_core_model core_u (.clk_in(clk_sys_in), .req_out(ps_req_in), .rdata_in(ps_rdata_out), .rvalid_in(ps_rvalid_out));
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    core_u.ps_rd(a, d);
    chk(d, e);
  endtask : rchk
  task automatic otp(input logic [31:0] w);
    @(negedge clk_sys_in);
    otp_sec_word_in = w;
    otp_load_in = 1'b1;
    @(negedge clk_sys_in);
    otp_load_in = 1'b0;
  endtask : otp
  task automatic t_sec();
    otp(32'h0000_0011);
    rchk(OFF_SEC_CFG, 32'h0000_0011);
    chk({22'h0, sec_ctrl_out}, 32'h0000_0101);
    core_u.ps_wr(OFF_SEC_CFG, 32'h7fff_ffff);
    chk({31'h0, ps_werr_out}, 32'h0000_0000);
    rchk(OFF_SEC_CFG, 32'h0000_5fb1);
    chk({22'h0, sec_ctrl_out}, 32'h0000_03ff);
    core_u.ps_wr(OFF_SEC_CFG, 32'h8000_0000);
    core_u.ps_wr(OFF_SEC_CFG, 32'h0000_0021);
    chk({31'h0, ps_werr_out}, 32'h0000_0001);
    rchk(OFF_SEC_CFG, 32'h8000_0000);
    otp(32'h0000_0020);
    rchk(OFF_SEC_CFG, 32'h0000_0020);
    chk({22'h0, sec_ctrl_out}, 32'h0000_0002);
    rchk(OFF_RAM_SIZE, RAM_B & RAM_SIZE_MASK);
    rchk(OFF_DBG_CAUSE, 32'h0000_0000);
    $display("test security done");
  endtask : t_sec
  task automatic t_osc();
    rchk(OFF_RO_CTRL, 32'h0000_0000);
    core_u.ps_wr(OFF_RO_CTRL, 32'hffff_ffff);
    rchk(OFF_RO_CTRL, 32'h0000_0003);
    repeat (20) @(negedge clk_sys_in);
    core_u.ps_wr(OFF_RO_CTRL, 32'h0000_0000);
    repeat (STOP_SETTLE_CYCLES) @(negedge clk_sys_in);
    for (int i = 0; i < 4; i++) begin
      core_u.ps_rd(OFF_RO_TCELL + 8'(i), cnt[i]);
      rchk(OFF_RO_TCELL + 8'(i), cnt[i]);
      chk({cnt[i][31:16], 15'h0, cnt[i] == 0}, 32'h0000_0000);
    end
    arst_n_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    for (int i = 0; i < 4; i++) rchk(OFF_RO_TCELL + 8'(i), cnt[i]);
    core_u.ps_wr(OFF_RO_CTRL, 32'h0000_0001);
    repeat (20) @(negedge clk_sys_in);
    core_u.ps_wr(OFF_RO_CTRL, 32'h0000_0000);
    repeat (STOP_SETTLE_CYCLES) @(negedge clk_sys_in);
    for (int i = 0; i < 4; i++) begin
      core_u.ps_rd(OFF_RO_TCELL + 8'(i), v);
      chk({31'h0, v === cnt[i]}, {31'h0, i < 2});
    end
    $display("test oscillators done");
  endtask : t_osc
  task automatic t_dbg();
    for (int c = 1; c < 6; c++) begin
      @(negedge clk_sys_in);
      dbg_entry_in = '{1'b1, psd_cause_t'(c), 8'h5a, 4'b0110, 32'hffff_ffff, 32'h1234_5670 + c, 32'h8765_4320 + c};
      @(negedge clk_sys_in);
      dbg_entry_in.valid = 1'b0;
      rchk(OFF_DBG_CAUSE, {14'h0, 1'b0, c > 2, (c == 1) ? 8'h00 : 8'h5a, 5'h0, 3'(c)});
      rchk(OFF_DBG_STATUS, 32'h0000_07df);
      rchk(OFF_DBG_PC, 32'h1234_5670 + c);
      rchk(OFF_DBG_SP, 32'h8765_4320 + c);
    end
    $display("test debug entry done");
  endtask : t_dbg
  task automatic t_dwr();
    core_u.ps_wr(OFF_DBG_PC, 32'h0bad_0bad);
    rchk(OFF_DBG_PC, 32'h1234_5675);
    debug_mode_in = 1'b1;
    core_u.ps_wr(OFF_THREAD_SEL, 32'hffff_ffff);
    core_u.ps_wr(OFF_REG_SEL, 32'hffff_ffff);
    core_u.ps_wr(OFF_DBG_CAUSE, 32'hffff_ffff);
    core_u.ps_wr(OFF_DBG_SP, 32'hcafe_f00d);
    rchk(OFF_THREAD_SEL, 32'h0000_00ff);
    rchk(OFF_REG_SEL, 32'h0000_001f);
    rchk(OFF_DBG_CAUSE, DBG_CAUSE_MASK);
    rchk(OFF_DBG_SP, 32'hcafe_f00d);
    chk({19'h0, thread_sel_out, reg_sel_out}, 32'h0000_1fff);
    debug_mode_in = 1'b0;
    core_u.ps_wr(OFF_THREAD_SEL, 32'h0000_0000);
    rchk(OFF_THREAD_SEL, 32'h0000_00ff);
    $display("test debug writes done");
  endtask : t_dwr
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    t_sec();
    t_osc();
    t_dbg();
    t_dwr();
    end_sim();
  end
endmodule : psd_status_regs_tb

// ==== verilog/psd_pkg.sv ====
package psd_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RO_W   = 16;

  localparam logic [7:0] OFF_SEC_CFG      = 8'h05;
  localparam logic [7:0] OFF_RO_CTRL      = 8'h06;
  localparam logic [7:0] OFF_RO_TCELL     = 8'h07;
  localparam logic [7:0] OFF_RO_TWIRE     = 8'h08;
  localparam logic [7:0] OFF_RO_PCELL     = 8'h09;
  localparam logic [7:0] OFF_RO_PWIRE     = 8'h0a;
  localparam logic [7:0] OFF_RAM_SIZE     = 8'h0c;
  localparam logic [7:0] OFF_DBG_STATUS   = 8'h10;
  localparam logic [7:0] OFF_DBG_PC       = 8'h11;
  localparam logic [7:0] OFF_DBG_SP       = 8'h12;
  localparam logic [7:0] OFF_THREAD_SEL   = 8'h13;
  localparam logic [7:0] OFF_REG_SEL      = 8'h14;
  localparam logic [7:0] OFF_DBG_CAUSE    = 8'h15;

  localparam int unsigned SEC_WLOCK_BIT    = 31;
  localparam int unsigned SEC_GDBG_BIT     = 14;
  localparam int unsigned SEC_OTP_ALL_BIT  = 12;
  localparam int unsigned SEC_OTP_SEC_LSB  = 8;
  localparam int unsigned SEC_OTP_RED_BIT  = 7;
  localparam int unsigned SEC_OTP_BOOT_BIT = 5;
  localparam int unsigned SEC_PLL_JTAG_BIT = 4;
  localparam int unsigned SEC_TAP_BIT      = 0;
  localparam logic [31:0] SEC_CFG_MASK     = 32'h8000_5fb1;

  localparam int unsigned RO_CORE_BIT   = 1;
  localparam int unsigned RO_PERIPH_BIT = 0;
  localparam logic [31:0] RO_CTRL_MASK  = 32'h0000_0003;
  localparam logic [31:0] RO_CTRL_RESET = 32'h0000_0000;

  localparam logic [31:0] DBG_STATUS_MASK = 32'h0000_07df;
  localparam logic [31:0] THREAD_SEL_MASK = 32'h0000_00ff;
  localparam logic [31:0] REG_SEL_MASK    = 32'h0000_001f;
  localparam logic [31:0] DBG_CAUSE_MASK  = 32'h0003_ff07;
  localparam logic [31:0] RAM_SIZE_MASK   = 32'hffff_fffc;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

  localparam int unsigned CAUSE_PT_LSB  = 16;
  localparam int unsigned CAUSE_THR_LSB = 8;

  localparam int unsigned STOP_SETTLE_CYCLES = 10;

  typedef enum logic [2:0] {
    PSD_CAUSE_NONE   = 3'b000,
    PSD_CAUSE_HOST   = 3'b001,
    PSD_CAUSE_DEBUG_CALL_INSTRUCTION  = 3'b010,
    PSD_CAUSE_IBREAK = 3'b011,
    PSD_CAUSE_DWATCH = 3'b100,
    PSD_CAUSE_RWATCH = 3'b101
  } psd_cause_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } psd_ps_req_t;

  typedef struct packed {
    logic       valid;
    psd_cause_t cause;
    logic [7:0] thread;
    logic [3:0] trig;
    logic [31:0] status_word;
    logic [31:0] pc;
    logic [31:0] sp;
  } psd_dbg_entry_t;

  typedef struct packed {
    logic       gdbg_block;
    logic       tap_block;
    logic       otp_all_lock;
    logic [3:0] otp_sector_lock;
    logic       otp_redundancy;
    logic       otp_boot;
    logic       pll_jtag_block;
  } psd_sec_ctrl_t;

endpackage : psd_pkg

// ==== verilog/psd_ring_osc_counter.sv ====
`timescale 1ns/1ps
module psd_ring_osc_counter
  import psd_pkg::*;
#(
  parameter int unsigned WIDTH = RO_W
) (
  input  wire logic             osc_clk_in,
  input  wire logic             run_in,
  output logic [WIDTH-1:0]      count_out
);

  initial begin
    if (WIDTH < 1 || WIDTH > 32) $error("psd_ring_osc_counter WIDTH out of range");
  end

  // No reset: counts survive a system reset, oscillator is asynchronous to the tile
  logic             run_meta_reg;
  logic             run_sync_reg;
  // Power-up value only; no system reset ever clears the count
  logic [WIDTH-1:0] count_reg = '0;

  always_ff @(posedge osc_clk_in) begin
    run_meta_reg <= run_in;
    run_sync_reg <= run_meta_reg;
  end

  always_ff @(posedge osc_clk_in) begin
    if (run_sync_reg) begin
      count_reg <= count_reg + WIDTH'(1);
    end
  end

  assign count_out = count_reg;

endmodule : psd_ring_osc_counter

// ==== verilog/psd_status_regs.sv ====
`timescale 1ns/1ps
module psd_status_regs
  import psd_pkg::*;
#(
  parameter logic [31:0] RAM_BYTES = 32'h0004_0000
) (
  input  wire logic           clk_sys_in,
  input  wire logic           arst_n_in,
  input  wire psd_ps_req_t    ps_req_in,
  output logic [31:0]         ps_rdata_out,
  output logic                ps_rvalid_out,
  output logic                ps_werr_out,
  input  wire logic           otp_load_in,
  input  wire logic [31:0]    otp_sec_word_in,
  input  wire logic           debug_mode_in,
  input  wire psd_dbg_entry_t dbg_entry_in,
  input  wire logic [3:0]     ring_osc_clk_in,
  output psd_sec_ctrl_t       sec_ctrl_out,
  output logic [7:0]          thread_sel_out,
  output logic [4:0]          reg_sel_out
);

  initial begin
    if ((RAM_BYTES & ~RAM_SIZE_MASK) != ZERO_WORD) $error("RAM_BYTES must be word aligned");
  end

  logic [31:0] sec_cfg_reg;
  logic [31:0] ro_ctrl_reg;
  logic [31:0] dbg_status_reg;
  logic [31:0] dbg_pc_reg;
  logic [31:0] dbg_sp_reg;
  logic [31:0] thread_sel_reg;
  logic [31:0] reg_sel_reg;
  logic [31:0] dbg_cause_reg;
  logic [31:0] rdata_reg;
  logic        rvalid_reg;
  logic        werr_reg;
  logic [RO_W-1:0] ro_count [4];
  logic [RO_W-1:0] ro_sync1_reg [4];
  logic [RO_W-1:0] ro_sync2_reg [4];

  // Masked write merge: reserved bits never stored
  function automatic logic [31:0] mwr(input logic [31:0] d, input logic [31:0] m);
    mwr = d & m;
  endfunction : mwr

  // Lowest set trigger number wins when several fire together
  function automatic logic [1:0] lowest(input logic [3:0] t);
    lowest = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (t[i]) begin
        lowest = 2'(i);
      end
    end
  endfunction : lowest

  logic wr_any;
  logic dbg_wr;
  assign wr_any = ps_req_in.wr;
  assign dbg_wr = wr_any && debug_mode_in;

  // Security copy; the OTP load is the hardware path and ignores the lock
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sec_cfg_reg <= ZERO_WORD;
    end else if (otp_load_in) begin
      sec_cfg_reg <= mwr(otp_sec_word_in, SEC_CFG_MASK);
    end else if (wr_any && ps_req_in.addr == OFF_SEC_CFG && !sec_cfg_reg[SEC_WLOCK_BIT]) begin
      sec_cfg_reg <= mwr(ps_req_in.wdata, SEC_CFG_MASK);
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      werr_reg <= 1'b0;
    end else begin
      werr_reg <= wr_any && ps_req_in.addr == OFF_SEC_CFG && sec_cfg_reg[SEC_WLOCK_BIT] && !otp_load_in;
    end
  end

  always_comb begin
    sec_ctrl_out.gdbg_block      = sec_cfg_reg[SEC_GDBG_BIT];
    sec_ctrl_out.tap_block       = sec_cfg_reg[SEC_TAP_BIT];
    sec_ctrl_out.otp_all_lock    = sec_cfg_reg[SEC_OTP_ALL_BIT];
    // An all-lock implies every sector lock
    sec_ctrl_out.otp_sector_lock = sec_cfg_reg[SEC_OTP_SEC_LSB +: 4] | {4{sec_cfg_reg[SEC_OTP_ALL_BIT]}};
    sec_ctrl_out.otp_redundancy  = sec_cfg_reg[SEC_OTP_RED_BIT];
    sec_ctrl_out.otp_boot        = sec_cfg_reg[SEC_OTP_BOOT_BIT];
    sec_ctrl_out.pll_jtag_block  = sec_cfg_reg[SEC_PLL_JTAG_BIT];
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ro_ctrl_reg <= RO_CTRL_RESET;
    end else if (wr_any && ps_req_in.addr == OFF_RO_CTRL) begin
      ro_ctrl_reg <= mwr(ps_req_in.wdata, RO_CTRL_MASK);
    end
  end

  // Tile cell, tile wire on core enable; peripheral cell, wire on peripheral enable
  for (genvar g = 0; g < 4; g++) begin : g_osc
    psd_ring_osc_counter #(
      .WIDTH (RO_W)
    ) u_cnt (
      .osc_clk_in (ring_osc_clk_in[g]),
      .run_in     (g < 2 ? ro_ctrl_reg[RO_CORE_BIT] : ro_ctrl_reg[RO_PERIPH_BIT]),
      .count_out  (ro_count[g])
    );
  end

  // Counts are only stable once stopped; reading while running may tear bits
  always_ff @(posedge clk_sys_in) begin
    for (int i = 0; i < 4; i++) begin
      ro_sync1_reg[i] <= ro_count[i];
      ro_sync2_reg[i] <= ro_sync1_reg[i];
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dbg_status_reg <= ZERO_WORD;
      dbg_pc_reg     <= ZERO_WORD;
      dbg_sp_reg     <= ZERO_WORD;
    end else if (dbg_entry_in.valid) begin
      dbg_status_reg <= mwr(dbg_entry_in.status_word, DBG_STATUS_MASK);
      dbg_pc_reg     <= dbg_entry_in.pc;
      dbg_sp_reg     <= dbg_entry_in.sp;
    end else if (dbg_wr) begin
      if (ps_req_in.addr == OFF_DBG_STATUS) begin
        // Bit 8 is read-only: keep captured value
        dbg_status_reg <= (mwr(ps_req_in.wdata, DBG_STATUS_MASK) & ~32'h0000_0100) |
                          (dbg_status_reg & 32'h0000_0100);
      end
      if (ps_req_in.addr == OFF_DBG_PC) begin
        dbg_pc_reg <= ps_req_in.wdata;
      end
      if (ps_req_in.addr == OFF_DBG_SP) begin
        dbg_sp_reg <= ps_req_in.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      thread_sel_reg <= ZERO_WORD;
      reg_sel_reg    <= ZERO_WORD;
    end else if (dbg_wr) begin
      if (ps_req_in.addr == OFF_THREAD_SEL) begin
        thread_sel_reg <= mwr(ps_req_in.wdata, THREAD_SEL_MASK);
      end
      if (ps_req_in.addr == OFF_REG_SEL) begin
        reg_sel_reg <= mwr(ps_req_in.wdata, REG_SEL_MASK);
      end
    end
  end

  assign thread_sel_out = thread_sel_reg[7:0];
  assign reg_sel_out    = reg_sel_reg[4:0];

  // Hardware capture wins over a same-cycle software write
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dbg_cause_reg <= ZERO_WORD;
    end else if (dbg_entry_in.valid) begin
      dbg_cause_reg <= ZERO_WORD;
      dbg_cause_reg[2:0] <= dbg_entry_in.cause;
      if (dbg_entry_in.cause != PSD_CAUSE_HOST) begin
        dbg_cause_reg[CAUSE_THR_LSB +: 8] <= dbg_entry_in.thread;
      end
      if (dbg_entry_in.cause != PSD_CAUSE_HOST && dbg_entry_in.cause != PSD_CAUSE_DEBUG_CALL_INSTRUCTION) begin
        dbg_cause_reg[CAUSE_PT_LSB +: 2] <= lowest(dbg_entry_in.trig);
      end
    end else if (dbg_wr && ps_req_in.addr == OFF_DBG_CAUSE) begin
      dbg_cause_reg <= mwr(ps_req_in.wdata, DBG_CAUSE_MASK);
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    case (ps_req_in.addr)
      OFF_SEC_CFG:    rd_mux = sec_cfg_reg;
      OFF_RO_CTRL:    rd_mux = ro_ctrl_reg;
      OFF_RO_TCELL:   rd_mux = {16'h0000, ro_sync2_reg[0]};
      OFF_RO_TWIRE:   rd_mux = {16'h0000, ro_sync2_reg[1]};
      OFF_RO_PCELL:   rd_mux = {16'h0000, ro_sync2_reg[2]};
      OFF_RO_PWIRE:   rd_mux = {16'h0000, ro_sync2_reg[3]};
      OFF_RAM_SIZE:   rd_mux = RAM_BYTES & RAM_SIZE_MASK;
      OFF_DBG_STATUS: rd_mux = dbg_status_reg;
      OFF_DBG_PC:     rd_mux = dbg_pc_reg;
      OFF_DBG_SP:     rd_mux = dbg_sp_reg;
      OFF_THREAD_SEL: rd_mux = thread_sel_reg;
      OFF_REG_SEL:    rd_mux = reg_sel_reg;
      OFF_DBG_CAUSE:  rd_mux = dbg_cause_reg;
      default:        rd_mux = ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_reg  <= ZERO_WORD;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= ps_req_in.rd;
      if (ps_req_in.rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign ps_rdata_out  = rdata_reg;
  assign ps_rvalid_out = rvalid_reg;
  assign ps_werr_out   = werr_reg;

endmodule : psd_status_regs
